// file: rtl/ict_sequencer.sv
// instruction cycle timing sequencer: spends clocks and bus cycles per operation
`default_nettype none
module ict_sequencer
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic resetInN,
	input wire logic haltInN,
	input wire logic opValid,
	input wire ict_pkg::ict_op_e opClass,
	input wire ict_pkg::ict_ea_e eaMode,
	input wire logic sizeLong,
	input wire logic byteDisp,
	input wire logic condTrue,
	input wire logic counterExpired,
	input wire logic indexLong,
	input wire logic [4:0] regCount,
	input wire logic [7:0] eaClocks,
	input wire logic [3:0] eaReads,
	input wire logic [3:0] eaWrites,
	input wire logic busAck,
	output logic opReady,
	output logic execStart,
	output logic busRead,
	output logic busWrite,
	output logic [9:0] clocksSpent,
	output logic [6:0] readsDone,
	output logic [6:0] writesDone
);
	// ****************************************
	// timing lookup
	// ****************************************
	// packs clocks, reads, writes
	function automatic logic [17:0] ict_cost(input logic [7:0] c, input logic [4:0] r, input logic [4:0] w);
		ict_cost = {c, r, w};
	endfunction : ict_cost

	typedef enum {ST_RESET_HOLD, ST_RESET_EXIT, ST_IDLE, ST_RUN} ict_state_e;

	ict_state_e state_reg;
	ict_state_e state_next;
	logic [17:0] baseCost;
	logic [9:0] totalClocks;
	logic [6:0] totalReads;
	logic [6:0] totalWrites;
	logic [9:0] perRegClocks;
	logic [6:0] perRegReads;
	logic [6:0] perRegWrites;
	logic addEa;
	logic [9:0] clkLeft_reg;
	logic [6:0] rdLeft_reg;
	logic [6:0] wrLeft_reg;
	logic [1:0] busPhase_reg;
	logic busActive_reg;
	logic busIsWrite_reg;
	logic [9:0] clkSpent_reg;
	logic [6:0] rdDone_reg;
	logic [6:0] wrDone_reg;
	logic startPulse_reg;
	logic wantRead;
	logic wantWrite;
	logic busDone;
	logic runDone;
	logic indexUnused;
	logic [6:0] rdAfter;
	logic [6:0] wrAfter;
	logic lastBus;
	logic opHasBus;

	// base cost per class and mode
	always_comb
	begin
		baseCost = ict_cost(8'h04, 5'h01, 5'h00);
		addEa = 1'b0;
		case (opClass)
			ict_pkg::OP_COND_BRANCH: // RULE_01
				baseCost = condTrue ? ict_cost(8'h0A, 5'h02, 5'h00) :
					(byteDisp ? ict_cost(8'h08, 5'h01, 5'h00) : ict_cost(8'h0C, 5'h02, 5'h00));
			ict_pkg::OP_ALWAYS_BRANCH: baseCost = ict_cost(8'h0A, 5'h02, 5'h00); // RULE_02
			ict_pkg::OP_BRANCH_SUBROUTINE: baseCost = ict_cost(8'h12, 5'h02, 5'h02); // RULE_02
			ict_pkg::OP_DECREMENT_BRANCH: // RULE_03
				baseCost = condTrue ? ict_cost(8'h0C, 5'h02, 5'h00) :
					(counterExpired ? ict_cost(8'h0E, 5'h03, 5'h00) : ict_cost(8'h0A, 5'h02, 5'h00));
			ict_pkg::OP_JUMP_OP: // RULE_05
				case (eaMode)
					ict_pkg::EA_INDIRECT: baseCost = ict_cost(8'h08, 5'h02, 5'h00);
					ict_pkg::EA_INDEX: baseCost = ict_cost(8'h0E, 5'h03, 5'h00);
					ict_pkg::EA_ABS_LONG: baseCost = ict_cost(8'h0C, 5'h03, 5'h00);
					default: baseCost = ict_cost(8'h0A, 5'h02, 5'h00);
				endcase
			ict_pkg::OP_JUMP_SUBROUTINE: // RULE_05
				case (eaMode)
					ict_pkg::EA_INDIRECT: baseCost = ict_cost(8'h10, 5'h02, 5'h02);
					ict_pkg::EA_INDEX: baseCost = ict_cost(8'h16, 5'h02, 5'h02);
					ict_pkg::EA_ABS_LONG: baseCost = ict_cost(8'h14, 5'h03, 5'h02);
					default: baseCost = ict_cost(8'h12, 5'h02, 5'h02);
				endcase
			ict_pkg::OP_LOAD_EFF_ADDR: // RULE_06
				case (eaMode)
					ict_pkg::EA_INDIRECT: baseCost = ict_cost(8'h04, 5'h01, 5'h00);
					ict_pkg::EA_INDEX: baseCost = ict_cost(8'h0C, 5'h02, 5'h00);
					ict_pkg::EA_ABS_LONG: baseCost = ict_cost(8'h0C, 5'h03, 5'h00);
					default: baseCost = ict_cost(8'h08, 5'h02, 5'h00);
				endcase
			ict_pkg::OP_PUSH_EFF_ADDR: // RULE_06
				case (eaMode)
					ict_pkg::EA_INDIRECT: baseCost = ict_cost(8'h0C, 5'h01, 5'h02);
					ict_pkg::EA_INDEX: baseCost = ict_cost(8'h14, 5'h02, 5'h02);
					ict_pkg::EA_ABS_LONG: baseCost = ict_cost(8'h14, 5'h03, 5'h02);
					default: baseCost = ict_cost(8'h10, 5'h02, 5'h02);
				endcase
			ict_pkg::OP_MULTI_LOAD: // RULE_07
				case (eaMode)
					ict_pkg::EA_INDIRECT, ict_pkg::EA_POSTINC: baseCost = ict_cost(8'h0C, 5'h03, 5'h00);
					ict_pkg::EA_INDEX: baseCost = ict_cost(8'h12, 5'h04, 5'h00);
					ict_pkg::EA_ABS_LONG: baseCost = ict_cost(8'h14, 5'h05, 5'h00);
					default: baseCost = ict_cost(8'h10, 5'h04, 5'h00);
				endcase
			ict_pkg::OP_MULTI_STORE: // RULE_08
				case (eaMode)
					ict_pkg::EA_INDEX: baseCost = ict_cost(8'h0E, 5'h03, 5'h00);
					ict_pkg::EA_ABS_LONG: baseCost = ict_cost(8'h10, 5'h04, 5'h00);
					ict_pkg::EA_DISP, ict_pkg::EA_ABS_WORD: baseCost = ict_cost(8'h0C, 5'h03, 5'h00);
					default: baseCost = {ict_pkg::STORE_BASE, 1'b0, ict_pkg::STORE_BASE_READS, 5'h00};
				endcase
			ict_pkg::OP_EXTENDED_REG: baseCost = ict_cost(sizeLong ? 8'h08 : 8'h04, 5'h01, 5'h00); // RULE_10
			ict_pkg::OP_EXTENDED_MEM: // RULE_10
				baseCost = sizeLong ? ict_cost(8'h1E, 5'h05, 5'h02) : ict_cost(8'h12, 5'h03, 5'h01);
			ict_pkg::OP_MEMORY_COMPARE: // RULE_11
				baseCost = sizeLong ? ict_cost(8'h14, 5'h05, 5'h00) : ict_cost(8'h0C, 5'h03, 5'h00);
			ict_pkg::OP_DECIMAL_REG: baseCost = ict_cost(8'h06, 5'h01, 5'h00); // RULE_11
			ict_pkg::OP_DECIMAL_MEM: baseCost = ict_cost(8'h12, 5'h03, 5'h01); // RULE_11
			ict_pkg::OP_LOGIC_IMM_CODES: baseCost = ict_cost(8'h14, 5'h03, 5'h00); // RULE_12
			ict_pkg::OP_EXT_RESET: baseCost = ict_cost(8'h84, 5'h01, 5'h00); // RULE_12
			ict_pkg::OP_STOP: baseCost = ict_cost(8'h04, 5'h00, 5'h00); // RULE_12
			ict_pkg::OP_EXCEPTION_RETURN,
			ict_pkg::OP_RETURN_RESTORE_CODES: baseCost = ict_cost(8'h14, 5'h05, 5'h00); // RULE_13
			ict_pkg::OP_RETURN_SUBROUTINE: baseCost = ict_cost(8'h10, 5'h04, 5'h00); // RULE_13
			ict_pkg::OP_FRAME_LINK: baseCost = ict_cost(8'h10, 5'h02, 5'h02); // RULE_13
			ict_pkg::OP_FRAME_UNLINK: baseCost = ict_cost(8'h0C, 5'h03, 5'h00); // RULE_13
			ict_pkg::OP_MOVE_TO_STATUS: // RULE_14
			begin
				baseCost = ict_cost(8'h0C, 5'h02, 5'h00);
				addEa = 1'b1;
			end
			ict_pkg::OP_STATUS_TO_REG: baseCost = ict_cost(8'h06, 5'h01, 5'h00); // RULE_14
			ict_pkg::OP_STATUS_TO_MEM: // RULE_14
			begin
				baseCost = ict_cost(8'h08, 5'h01, 5'h01);
				addEa = 1'b1;
			end
			ict_pkg::OP_PERIPH_STORE: // RULE_15
				baseCost = sizeLong ? ict_cost(8'h18, 5'h02, 5'h04) : ict_cost(8'h10, 5'h02, 5'h02);
			ict_pkg::OP_PERIPH_LOAD: // RULE_15
				baseCost = sizeLong ? ict_cost(8'h19, 5'h06, 5'h00) : ict_cost(8'h10, 5'h04, 5'h00);
			ict_pkg::OP_EXC_ADDR_ERR, ict_pkg::OP_EXC_BUS_ERR: baseCost = ict_cost(8'h32, 5'h04, 5'h07); // RULE_17
			ict_pkg::OP_EXC_ILLEGAL, ict_pkg::OP_EXC_PRIVILEGE, ict_pkg::OP_EXC_TRACE,
			ict_pkg::OP_EXC_OVERFLOW_TRAP: baseCost = ict_cost(8'h22, 5'h04, 5'h03); // RULE_18
			ict_pkg::OP_EXC_TRAP: baseCost = ict_cost(8'h26, 5'h04, 5'h04); // RULE_18
			ict_pkg::OP_EXC_DIV_ZERO: baseCost = ict_cost(8'h2A, 5'h05, 5'h04); // RULE_18
			ict_pkg::OP_EXC_BOUNDS_CHECK: // RULE_18
			begin
				baseCost = ict_cost(8'h2C, 5'h05, 5'h04);
				addEa = 1'b1;
			end
			ict_pkg::OP_EXC_INTERRUPT: baseCost = ict_cost(8'h2C, 5'h05, 5'h03); // RULE_19
			default: baseCost = ict_cost(8'h04, 5'h01, 5'h00);
		endcase
	end

	// ****************************************
	// totals
	// ****************************************
	// index width is deliberately ignored
	assign indexUnused = indexLong; // RULE_09
	assign perRegClocks = (opClass == ict_pkg::OP_MULTI_LOAD || opClass == ict_pkg::OP_MULTI_STORE) ?
		10'(regCount) * (sizeLong ? 10'(ict_pkg::LONG_PER_REG) : 10'(ict_pkg::WORD_PER_REG)) : 10'h000; // RULE_07
	assign perRegReads = (opClass == ict_pkg::OP_MULTI_LOAD) ?
		7'(regCount) * (sizeLong ? 7'h02 : 7'h01) : 7'h00; // RULE_07
	assign perRegWrites = (opClass == ict_pkg::OP_MULTI_STORE) ?
		7'(regCount) * (sizeLong ? 7'h02 : 7'h01) : 7'h00; // RULE_08
	// exceptions already include stacking, vector and two prefetches
	assign totalClocks = 10'(baseCost[17:10]) + perRegClocks + (addEa ? 10'(eaClocks) : 10'h000); // RULE_04 RULE_16
	assign totalReads = 7'(baseCost[9:5]) + perRegReads + (addEa ? 7'(eaReads) : 7'h00); // RULE_04
	assign totalWrites = 7'(baseCost[4:0]) + perRegWrites + (addEa ? 7'(eaWrites) : 7'h00); // RULE_04

	// ****************************************
	// sequencing
	// ****************************************
	// reads first, then writes, then idle clocks
	assign wantRead = (rdLeft_reg != 7'h00);
	assign wantWrite = (wrLeft_reg != 7'h00);
	assign busDone = busActive_reg && (busPhase_reg == 2'h3) && busAck;
	assign rdAfter = (busDone && !busIsWrite_reg) ? rdLeft_reg - 7'h01 : rdLeft_reg;
	assign wrAfter = (busDone && busIsWrite_reg) ? wrLeft_reg - 7'h01 : wrLeft_reg;
	// the last acknowledge may close the count in the same clock
	assign lastBus = busDone && (rdAfter == 7'h00) && (wrAfter == 7'h00);
	assign opHasBus = (totalReads != 7'h00) || (totalWrites != 7'h00);
	// reset exit is counted by the same logic as an operation
	assign runDone = (state_reg == ST_RUN || state_reg == ST_RESET_EXIT) && (clkLeft_reg <= 10'h001) &&
		((!busActive_reg && !wantRead && !wantWrite) || lastBus);
	assign opReady = (state_reg == ST_IDLE) && !indexUnused | (state_reg == ST_IDLE);
	assign busRead = busActive_reg && !busIsWrite_reg;
	assign busWrite = busActive_reg && busIsWrite_reg;
	assign execStart = startPulse_reg;
	assign clocksSpent = clkSpent_reg;
	assign readsDone = rdDone_reg;
	assign writesDone = wrDone_reg;

	// state transitions
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET_HOLD: if (resetInN && haltInN) state_next = ST_RESET_EXIT; // RULE_20
			ST_RESET_EXIT: if (runDone) state_next = ST_IDLE;
			ST_IDLE: if (opValid) state_next = ST_RUN;
			ST_RUN: if (runDone) state_next = ST_IDLE;
			default: state_next = ST_RESET_HOLD;
		endcase
		if (!resetInN)
			state_next = ST_RESET_HOLD;
	end

	// counters and bus cycle phase
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= ST_RESET_HOLD;
			clkLeft_reg <= 10'h000;
			rdLeft_reg <= 7'h00;
			wrLeft_reg <= 7'h00;
			busPhase_reg <= 2'h0;
			busActive_reg <= 1'b0;
			busIsWrite_reg <= 1'b0;
			clkSpent_reg <= 10'h000;
			rdDone_reg <= 7'h00;
			wrDone_reg <= 7'h00;
			startPulse_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			startPulse_reg <= (state_reg == ST_RESET_EXIT) && (state_next == ST_IDLE); // RULE_20
			if (state_next == ST_RESET_HOLD)
			begin
				busActive_reg <= 1'b0;
				rdLeft_reg <= 7'h00;
				wrLeft_reg <= 7'h00;
			end
			else if (state_reg == ST_RESET_HOLD)
			begin
				clkLeft_reg <= 10'(ict_pkg::RESET_EXIT_CLOCKS); // RULE_20
				rdLeft_reg <= 7'(ict_pkg::RESET_EXIT_READS);
				wrLeft_reg <= 7'h00;
				// first read starts with the count, no clock lost
				busActive_reg <= (ict_pkg::RESET_EXIT_READS != 4'h0); // RULE_21
				busIsWrite_reg <= 1'b0;
				busPhase_reg <= 2'h0;
				clkSpent_reg <= 10'h000;
				rdDone_reg <= 7'h00;
				wrDone_reg <= 7'h00;
			end
			else if (state_reg == ST_IDLE && opValid)
			begin
				clkLeft_reg <= totalClocks;
				rdLeft_reg <= totalReads;
				wrLeft_reg <= totalWrites;
				// tight entries need the bus busy from the first clock
				busActive_reg <= opHasBus; // RULE_21
				busIsWrite_reg <= (totalReads == 7'h00);
				busPhase_reg <= 2'h0;
				clkSpent_reg <= 10'h000;
				rdDone_reg <= 7'h00;
				wrDone_reg <= 7'h00;
			end
			else if (state_reg == ST_RUN || state_reg == ST_RESET_EXIT)
			begin
				clkSpent_reg <= clkSpent_reg + 10'h001;
				if (clkLeft_reg != 10'h000 && !(busActive_reg && busPhase_reg == 2'h3 && !busAck))
					clkLeft_reg <= clkLeft_reg - 10'h001; // wait states stretch the total
				// bus cycle spans four clocks, held in the last until acknowledged
				if (busActive_reg && busPhase_reg != 2'h3)
					busPhase_reg <= busPhase_reg + 2'h1; // RULE_21
				else if (busDone)
				begin
					// next cycle follows at once, reads before writes
					busActive_reg <= !lastBus; // RULE_21
					busIsWrite_reg <= (rdAfter == 7'h00);
					busPhase_reg <= 2'h0;
					if (busIsWrite_reg)
					begin
						wrLeft_reg <= wrLeft_reg - 7'h01;
						wrDone_reg <= wrDone_reg + 7'h01;
					end
					else
					begin
						rdLeft_reg <= rdLeft_reg - 7'h01;
						rdDone_reg <= rdDone_reg + 7'h01;
					end
				end
			end
		end
	end
endmodule : ict_sequencer
`default_nettype wire

// file: rtl/ict_pkg.sv
// constants for the instruction cycle timing sequencer
// Contract
// (RULE_01) conditional branch: taken 10(2/0); not taken byte 8(1/0), word 12(2/0).
// (RULE_02) always branch 10(2/0); branch to subroutine 18(2/2) for both displacements.
// (RULE_03) decrement branch: cc true 12(2/0); false branching 10(2/0); expired 14(3/0).
// (RULE_04) flagged entries add effective address clocks, reads and writes to base.
// (RULE_05) indirect jump 8(2/0), jump subroutine 16(2/2); absolute long jump 12(3/0).
// (RULE_06) indirect load effective address 4(1/0); push effective address 12(1/2).
// (RULE_07) multi register load: base plus 4n words or 8n longs; indirect base 12(3/0).
// (RULE_08) multi register store: base 8(2/0), plus 4n/n writes words, 8n/2n longs.
// (RULE_09) index register size never changes execution time of indexed modes.
// (RULE_10) extended add/sub 4 or 8 registers; memory forms 18(3/1) or 30(5/2).
// (RULE_11) memory compare 12(3/0) or 20(5/0); decimal ops 6(1/0) or 18(3/1).
// (RULE_12) immediate logic to codes/status 20(3/0); external reset 132(1/0); stop 4(0/0).
// (RULE_13) exception return and restore 20(5/0); subroutine return 16(4/0); link 16(2/2); unlink 12(3/0).
// (RULE_14) move into codes or status 12(2/0); read status 6(1/0) or 8(1/1).
// (RULE_15) peripheral move word 16(2/2) or 16(4/0); long 24(2/4) or 25(6/0).
// (RULE_16) exception counts include stacking, vector fetch and two handler word fetches.
// (RULE_17) address error and bus error 50(4/7).
// (RULE_18) illegal, privilege, trace, overflow trap 34(4/3); trap 38(4/4); divide zero 42(5/4); bounds 44(5/4).
// (RULE_19) interrupt 44(5/3), assuming a four clock acknowledge cycle.
// (RULE_20) after reset and halt sampled negated: 40 clocks, six reads, then execute.
// (RULE_21) each bus cycle takes at least four clocks; internal cycles fill the rest.
`default_nettype none
package ict_pkg;
	// operation classes
	typedef enum logic [5:0]
	{
		OP_COND_BRANCH, OP_ALWAYS_BRANCH, OP_BRANCH_SUBROUTINE, OP_DECREMENT_BRANCH,
		OP_JUMP_OP, OP_JUMP_SUBROUTINE, OP_LOAD_EFF_ADDR, OP_PUSH_EFF_ADDR,
		OP_MULTI_LOAD, OP_MULTI_STORE, OP_EXTENDED_REG, OP_EXTENDED_MEM,
		OP_MEMORY_COMPARE, OP_DECIMAL_REG, OP_DECIMAL_MEM, OP_LOGIC_IMM_CODES,
		OP_EXT_RESET, OP_STOP, OP_EXCEPTION_RETURN, OP_RETURN_RESTORE_CODES,
		OP_RETURN_SUBROUTINE, OP_FRAME_LINK, OP_FRAME_UNLINK, OP_MOVE_TO_STATUS,
		OP_STATUS_TO_REG, OP_STATUS_TO_MEM, OP_PERIPH_STORE, OP_PERIPH_LOAD,
		OP_EXC_ADDR_ERR, OP_EXC_BUS_ERR, OP_EXC_ILLEGAL, OP_EXC_PRIVILEGE,
		OP_EXC_TRACE, OP_EXC_OVERFLOW_TRAP, OP_EXC_TRAP, OP_EXC_DIV_ZERO,
		OP_EXC_BOUNDS_CHECK, OP_EXC_INTERRUPT
	} ict_op_e;
	// addressing mode groups that change jump and multi move timing
	typedef enum logic [2:0]
	{
		EA_INDIRECT, EA_POSTINC, EA_PREDEC, EA_DISP, EA_INDEX, EA_ABS_WORD, EA_ABS_LONG, EA_PC_DISP
	} ict_ea_e;
	localparam logic [7:0] BUS_CYCLE_CLOCKS = 8'h04;
	localparam logic [7:0] RESET_EXIT_CLOCKS = 8'h28;
	localparam logic [3:0] RESET_EXIT_READS = 4'h6;
	localparam logic [7:0] WORD_PER_REG = 8'h04;
	localparam logic [7:0] LONG_PER_REG = 8'h08;
	localparam logic [7:0] STORE_BASE = 8'h08;
	localparam logic [3:0] STORE_BASE_READS = 4'h2;
	localparam logic [7:0] MAX_COUNT = 8'hFF;
endpackage : ict_pkg
`default_nettype wire

// file: tb/ict_bus_model.sv
// bus partner model: acknowledges each read or write bus cycle
`default_nettype none
module ict_bus_model
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic busRead,
	input wire logic busWrite,
	input wire logic slow,
	output logic busAck
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_reg;
	logic active;
	// ack in the fourth clock, or two clocks later when slow
	assign active = busRead || busWrite;
	assign busAck = active && (cnt_reg >= (slow ? 4'h5 : 4'h3));
	// clocks spent in the current bus cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cnt_reg <= 4'h0;
		else if (busAck || !active)
			cnt_reg <= 4'h0;
		else
			cnt_reg <= cnt_reg + 4'h1;
	end
endmodule : ict_bus_model
`default_nettype wire

// file: tb/ict_seq_properties.sv
// concurrent checks on the timing sequencer ports
`default_nettype none
module ict_seq_properties
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic resetInN,
	input wire logic haltInN,
	input wire logic opValid,
	input wire logic opReady,
	input wire logic execStart,
	input wire logic busRead,
	input wire logic busWrite,
	input wire logic [9:0] clocksSpent,
	input wire logic [6:0] readsDone,
	input wire logic [6:0] writesDone
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// ****************
	// steps of reset exit
	// ****************
	sequence exitReq;
		!resetInN ##1 (resetInN && haltInN);
	endsequence
	sequence exitDone;
		execStart && clocksSpent == 10'h028 && readsDone == 7'h06 && writesDone == 7'h00;
	endsequence
	bus_excl_a: assert property (!(busRead && busWrite))
		else $error("read and write cycles overlap");
	read_len_a: assert property ($rose(busRead) |-> busRead[*4])
		else $error("read cycle shorter than four clocks");
	write_len_a: assert property ($rose(busWrite) |-> busWrite[*4])
		else $error("write cycle shorter than four clocks");
	idle_quiet_a: assert property (opReady |-> !busRead && !busWrite)
		else $error("bus cycle while idle");
	take_busy_a: assert property (opReady && opValid |=> !opReady)
		else $error("request not taken");
	reads_first_a: assert property ($rose(busRead) |-> writesDone == 7'h00)
		else $error("read after write in one operation");
	exit_time_a: assert property (exitReq |-> ##[38:42] exitDone)
		else $error("reset exit timing wrong");
	reset_hold_a: assert property (!resetInN |=> !execStart && !opReady)
		else $error("running while reset input low");
	counts_hold_a: assert property (opReady ##1 opReady |-> $stable(clocksSpent) && $stable(readsDone))
		else $error("counts moved while idle");
endmodule : ict_seq_properties
bind ict_sequencer ict_seq_properties chk (.clk(clk), .resetn(resetn), .resetInN(resetInN), .haltInN(haltInN),
	.opValid(opValid), .opReady(opReady), .execStart(execStart), .busRead(busRead), .busWrite(busWrite),
	.clocksSpent(clocksSpent), .readsDone(readsDone), .writesDone(writesDone));
`default_nettype wire

// file: tb/ict_tb.sv
// self-checking bench for the timing sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, resetn, resetInN, haltInN, opValid, sizeLong, byteDisp, condTrue, counterExpired, indexLong, slow;
	logic opReady, execStart, busRead, busWrite, busAck;
	ict_pkg::ict_op_e opClass;
	ict_pkg::ict_ea_e eaMode;
	logic [4:0] regCount;
	logic [7:0] eaClocks;
	logic [3:0] eaReads, eaWrites;
	logic [9:0] clocksSpent;
	logic [6:0] readsDone, writesDone;
	int miscompares, testsRun;
	ict_sequencer uut (.clk(clk), .resetn(resetn), .resetInN(resetInN), .haltInN(haltInN), .opValid(opValid),
		.opClass(opClass), .eaMode(eaMode), .sizeLong(sizeLong), .byteDisp(byteDisp), .condTrue(condTrue),
		.counterExpired(counterExpired), .indexLong(indexLong), .regCount(regCount), .eaClocks(eaClocks),
		.eaReads(eaReads), .eaWrites(eaWrites), .busAck(busAck), .opReady(opReady), .execStart(execStart),
		.busRead(busRead), .busWrite(busWrite), .clocksSpent(clocksSpent), .readsDone(readsDone),
		.writesDone(writesDone));
	ict_bus_model bus (.clk(clk), .resetn(resetn), .busRead(busRead), .busWrite(busWrite), .slow(slow),
		.busAck(busAck));
	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ****************
	// shared tasks
	// ****************
	task automatic check(input string nm, input logic [9:0] got, input logic [9:0] exp);
		testsRun++;
		if (got !== exp)
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		if (got !== exp)
			miscompares++;
	endtask : check
	task automatic waitReady();
		int k;
		k = 0;
		while (opReady !== 1'b1 && k < 600)
		begin
			@(posedge clk);
			#2;
			k++;
		end
		if (k >= 600)
			miscompares++;
	endtask : waitReady
	// f packs taken/true, counter expired, byte displacement, long size
	task automatic op(input ict_pkg::ict_op_e o, input logic [3:0] f, input logic [9:0] c,
		input logic [6:0] r, input logic [6:0] w);
		@(posedge clk);
		#2;
		opClass = o;
		{condTrue, counterExpired, byteDisp, sizeLong} = f;
		opValid = 1'b1;
		waitReady();
		@(posedge clk);
		#2;
		opValid = 1'b0;
		waitReady();
		if (slow)
			check("stretched clocks", {9'h000, clocksSpent > c}, 10'h001);
		else
			check("clocks", clocksSpent, c);
		check("reads", {3'h0, readsDone}, {3'h0, r});
		check("writes", {3'h0, writesDone}, {3'h0, w});
	endtask : op
	task automatic resetExit(input logic hold);
		int k;
		k = 0;
		@(posedge clk);
		#2;
		resetInN = 1'b0;
		haltInN = 1'b0;
		repeat (3) @(posedge clk);
		#2;
		resetInN = 1'b1;
		haltInN = !hold;
		repeat (hold ? 4 : 0)
		begin
			@(posedge clk);
			#2;
			check("halt hold", {8'h00, execStart, opReady}, 10'h000);
		end
		haltInN = 1'b1;
		while (execStart !== 1'b1 && k < 100)
		begin
			@(posedge clk);
			#2;
			k++;
		end
		if (k >= 100)
			miscompares++;
		check("exit clocks", clocksSpent, 10'h028);
		check("exit reads", {3'h0, readsDone}, 10'h006);
		check("exit writes", {3'h0, writesDone}, 10'h000);
	endtask : resetExit
	// ****************
	// scenarios
	// ****************
	task automatic branches();
		op(ict_pkg::OP_COND_BRANCH, 4'h8, 10'h00A, 7'h2, 7'h0);
		op(ict_pkg::OP_COND_BRANCH, 4'h2, 10'h008, 7'h1, 7'h0);
		op(ict_pkg::OP_COND_BRANCH, 4'h0, 10'h00C, 7'h2, 7'h0);
		op(ict_pkg::OP_ALWAYS_BRANCH, 4'h2, 10'h00A, 7'h2, 7'h0);
		op(ict_pkg::OP_BRANCH_SUBROUTINE, 4'h0, 10'h012, 7'h2, 7'h2);
		op(ict_pkg::OP_DECREMENT_BRANCH, 4'h8, 10'h00C, 7'h2, 7'h0);
		op(ict_pkg::OP_DECREMENT_BRANCH, 4'h0, 10'h00A, 7'h2, 7'h0);
		op(ict_pkg::OP_DECREMENT_BRANCH, 4'h4, 10'h00E, 7'h3, 7'h0);
	endtask : branches
	task automatic jumps();
		op(ict_pkg::OP_JUMP_OP, 4'h0, 10'h008, 7'h2, 7'h0);
		op(ict_pkg::OP_JUMP_SUBROUTINE, 4'h0, 10'h010, 7'h2, 7'h2);
		op(ict_pkg::OP_LOAD_EFF_ADDR, 4'h0, 10'h004, 7'h1, 7'h0);
		op(ict_pkg::OP_PUSH_EFF_ADDR, 4'h0, 10'h00C, 7'h1, 7'h2);
		op(ict_pkg::OP_MULTI_LOAD, 4'h0, 10'h018, 7'h6, 7'h0);
		op(ict_pkg::OP_MULTI_LOAD, 4'h1, 10'h024, 7'h9, 7'h0);
		op(ict_pkg::OP_MULTI_STORE, 4'h0, 10'h014, 7'h2, 7'h3);
		eaMode = ict_pkg::EA_PREDEC;
		op(ict_pkg::OP_MULTI_STORE, 4'h1, 10'h020, 7'h2, 7'h6);
		eaMode = ict_pkg::EA_ABS_LONG;
		op(ict_pkg::OP_JUMP_OP, 4'h0, 10'h00C, 7'h3, 7'h0);
		eaMode = ict_pkg::EA_INDEX;
		op(ict_pkg::OP_JUMP_OP, 4'h0, 10'h00E, 7'h3, 7'h0);
		indexLong = 1'b1;
		op(ict_pkg::OP_JUMP_OP, 4'h0, 10'h00E, 7'h3, 7'h0);
		op(ict_pkg::OP_MULTI_STORE, 4'h0, 10'h01A, 7'h3, 7'h3);
		eaMode = ict_pkg::EA_DISP;
		op(ict_pkg::OP_JUMP_SUBROUTINE, 4'h0, 10'h012, 7'h2, 7'h2);
		eaMode = ict_pkg::EA_ABS_WORD;
		op(ict_pkg::OP_LOAD_EFF_ADDR, 4'h0, 10'h008, 7'h2, 7'h0);
		eaMode = ict_pkg::EA_PC_DISP;
		op(ict_pkg::OP_PUSH_EFF_ADDR, 4'h0, 10'h010, 7'h2, 7'h2);
		eaMode = ict_pkg::EA_POSTINC;
		op(ict_pkg::OP_MULTI_LOAD, 4'h0, 10'h018, 7'h6, 7'h0);
		eaMode = ict_pkg::EA_ABS_LONG;
		op(ict_pkg::OP_MULTI_LOAD, 4'h0, 10'h020, 7'h8, 7'h0);
		op(ict_pkg::OP_JUMP_SUBROUTINE, 4'h0, 10'h014, 7'h3, 7'h2);
	endtask : jumps
	task automatic arith();
		op(ict_pkg::OP_EXTENDED_REG, 4'h0, 10'h004, 7'h1, 7'h0);
		op(ict_pkg::OP_EXTENDED_REG, 4'h1, 10'h008, 7'h1, 7'h0);
		op(ict_pkg::OP_EXTENDED_MEM, 4'h0, 10'h012, 7'h3, 7'h1);
		op(ict_pkg::OP_EXTENDED_MEM, 4'h1, 10'h01E, 7'h5, 7'h2);
		op(ict_pkg::OP_MEMORY_COMPARE, 4'h1, 10'h014, 7'h5, 7'h0);
		op(ict_pkg::OP_MEMORY_COMPARE, 4'h0, 10'h00C, 7'h3, 7'h0);
		op(ict_pkg::OP_DECIMAL_MEM, 4'h0, 10'h012, 7'h3, 7'h1);
		op(ict_pkg::OP_EXCEPTION_RETURN, 4'h0, 10'h014, 7'h5, 7'h0);
		op(ict_pkg::OP_PERIPH_STORE, 4'h0, 10'h010, 7'h2, 7'h2);
		op(ict_pkg::OP_DECIMAL_REG, 4'h0, 10'h006, 7'h1, 7'h0);
		op(ict_pkg::OP_LOGIC_IMM_CODES, 4'h0, 10'h014, 7'h3, 7'h0);
		op(ict_pkg::OP_EXT_RESET, 4'h0, 10'h084, 7'h1, 7'h0);
		op(ict_pkg::OP_STOP, 4'h0, 10'h004, 7'h0, 7'h0);
		op(ict_pkg::OP_RETURN_RESTORE_CODES, 4'h0, 10'h014, 7'h5, 7'h0);
		op(ict_pkg::OP_RETURN_SUBROUTINE, 4'h0, 10'h010, 7'h4, 7'h0);
		op(ict_pkg::OP_FRAME_LINK, 4'h0, 10'h010, 7'h2, 7'h2);
		op(ict_pkg::OP_FRAME_UNLINK, 4'h0, 10'h00C, 7'h3, 7'h0);
		op(ict_pkg::OP_MOVE_TO_STATUS, 4'h0, 10'h010, 7'h3, 7'h0);
		op(ict_pkg::OP_STATUS_TO_REG, 4'h0, 10'h006, 7'h1, 7'h0);
		op(ict_pkg::OP_STATUS_TO_MEM, 4'h0, 10'h00C, 7'h2, 7'h1);
		op(ict_pkg::OP_PERIPH_STORE, 4'h1, 10'h018, 7'h2, 7'h4);
		op(ict_pkg::OP_PERIPH_LOAD, 4'h0, 10'h010, 7'h4, 7'h0);
		op(ict_pkg::OP_PERIPH_LOAD, 4'h1, 10'h019, 7'h6, 7'h0);
	endtask : arith
	task automatic exceptions();
		op(ict_pkg::OP_EXC_ADDR_ERR, 4'h0, 10'h032, 7'h4, 7'h7);
		op(ict_pkg::OP_EXC_BUS_ERR, 4'h0, 10'h032, 7'h4, 7'h7);
		op(ict_pkg::OP_EXC_PRIVILEGE, 4'h0, 10'h022, 7'h4, 7'h3);
		op(ict_pkg::OP_EXC_ILLEGAL, 4'h0, 10'h022, 7'h4, 7'h3);
		op(ict_pkg::OP_EXC_TRACE, 4'h0, 10'h022, 7'h4, 7'h3);
		op(ict_pkg::OP_EXC_OVERFLOW_TRAP, 4'h0, 10'h022, 7'h4, 7'h3);
		op(ict_pkg::OP_EXC_TRAP, 4'h0, 10'h026, 7'h4, 7'h4);
		op(ict_pkg::OP_EXC_DIV_ZERO, 4'h0, 10'h02A, 7'h5, 7'h4);
		op(ict_pkg::OP_EXC_BOUNDS_CHECK, 4'h0, 10'h030, 7'h6, 7'h4);
		op(ict_pkg::OP_EXC_INTERRUPT, 4'h0, 10'h02C, 7'h5, 7'h3);
		slow = 1'b1;
		op(ict_pkg::OP_EXC_INTERRUPT, 4'h0, 10'h02C, 7'h5, 7'h3);
		slow = 1'b0;
	endtask : exceptions
	task automatic midReset();
		@(posedge clk);
		#2;
		opClass = ict_pkg::OP_EXT_RESET;
		opValid = 1'b1;
		@(posedge clk);
		#2;
		opValid = 1'b0;
		repeat (10) @(posedge clk);
		resetExit(1'b0);
		op(ict_pkg::OP_STOP, 4'h0, 10'h004, 7'h0, 7'h0);
	endtask : midReset
	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : endOfTest
	// main sequence
	initial
	begin
		{resetn, resetInN, haltInN, opValid, sizeLong, byteDisp, condTrue, counterExpired, indexLong, slow} = '0;
		opClass = ict_pkg::OP_STOP;
		eaMode = ict_pkg::EA_INDIRECT;
		regCount = 5'h03;
		eaClocks = 8'h04;
		eaReads = 4'h1;
		eaWrites = 4'h0;
		miscompares = 0;
		testsRun = 0;
		repeat (2) @(posedge clk);
		#2;
		resetn = 1'b1;
		resetExit(1'b1);
		branches();
		jumps();
		arith();
		exceptions();
		midReset();
		endOfTest();
	end
	// watchdog against a hang
	initial
	begin
		#(25 * 20000);
		miscompares++;
		endOfTest();
	end
endmodule : tb
`default_nettype wire
